//--- tic_params.svh
`ifndef TIC_PARAMS_SVH
`define TIC_PARAMS_SVH

// register addresses
`define TIC_ADDR_CONTROL   8'hA1
`define TIC_ADDR_FRACTION  8'hA2
`define TIC_ADDR_SECONDS   8'hA3
`define TIC_ADDR_MINUTES   8'hA4
`define TIC_ADDR_HOURS     8'hA5
`define TIC_ADDR_COMPARE   8'hA6

// control field positions
`define TIC_BIT_TIME_CLOCK_ENABLE       0
`define TIC_BIT_IEN        1
`define TIC_BIT_FLAG       2
`define TIC_BIT_SINGLE     3
`define TIC_BIT_TB_LO      4
`define TIC_BIT_TB_HI      5
`define TIC_BIT_WRAP24     6
`define TIC_CONTROL_MASK   8'h7F

// reset values
`define TIC_RESET_CONTROL  7'h00
`define TIC_RESET_COUNT    8'h00
`define TIC_RESET_COMPARE  8'h00

// wrap points
`define TIC_FRACTION_TOP   8'h7F
`define TIC_SECONDS_TOP    8'h3B
`define TIC_MINUTES_TOP    8'h3B
`define TIC_HOURS24_TOP    8'h17
`define TIC_HOURS256_TOP   8'hFF

// timing: one fraction step is 1/128 s
`define TIC_CLK_PERIOD_NS  20
`define TIC_STEP_NS        7812500
`define TIC_STEP_CYCLES    ((`TIC_STEP_NS + `TIC_CLK_PERIOD_NS - 1) / `TIC_CLK_PERIOD_NS)

`endif

//--- tic_pkg.sv
package tic_pkg;

  typedef enum logic [1:0] {
    TB_FRACTION,
    TB_SECONDS,
    TB_MINUTES,
    TB_HOURS
  } timebase_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_type;

  typedef struct packed {
    logic       day_wrap_24;
    logic [1:0] timebase_select;
    logic       single_interval;
    logic       interval_match_flag;
    logic       interval_enable;
    logic       time_clock_enable;
  } tic_control_type;

endpackage

//--- time_interval_counter.sv
// Behaviour
// - clearing interval enable stops the interval counter and zeroes it, setting it lets the counter run.
// - with single interval clear, each timeout reloads the interval counter and counting resumes.
// - the match flag is set on the interval tick at which the interval counter equals the compare value and stays until software clears it.
// - the match flag sits at control bit 2 and requests an interrupt only when its interrupt enable is set.
// - the compare register holds any software value from 0 to 255 and resets to zero.
// - with the time clock enabled the fraction count steps every 1/128 s, 0 to 127, then wraps and carries.
// - the seconds count steps once per second, 0 to 59, then wraps and carries into minutes.
// - the minutes count steps once per minute, 0 to 59, then wraps and carries into hours.
// - with the 24-hour bit set the hours count runs 0 to 23 then wraps to zero.
// - with the 24-hour bit clear the hours count runs 0 to 255 then wraps to zero.
// - fraction, seconds, minutes and hours reset to zero.
// - hours step only by the minutes carry and only while the time clock is enabled.
// - the timebase select picks the interval rate: 00 fraction, 01 seconds, 10 minutes, 11 hours.
// - with single interval set, a timeout clears interval enable so only one timeout occurs, except in a cycle with a control write, whose value stands.
`timescale 1ns/100ps
`default_nettype none
`include "tic_params.svh"

module time_interval_counter
  import tic_pkg::*;
#(
  parameter int STEP_CYCLES = `TIC_STEP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire sfr_req_type sfr_req,
  input  wire logic        irq_enable,
  output logic [7:0]       sfr_rdata,
  output logic             irq_request
);

  localparam int DIV_W = $clog2(STEP_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CYCLES - 1);

  // returns {carry, next value}; values above top are treated as at top
  function automatic logic [8:0] step_wrap(input logic [7:0] value, input logic [7:0] top, input logic en);
    logic [8:0] result;
    result = {1'b0, value};
    if (en) begin
      if (value >= top) begin
        result = {1'b1, 8'h00};
      end else begin
        result = {1'b0, value + 8'h01};
      end
    end
    return result;
  endfunction

  function automatic logic sfr_write(input sfr_req_type req, input logic [7:0] addr);
    return req.wr && (req.addr == addr);
  endfunction

  tic_control_type  control_reg;
  tic_control_type  control_next;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic [7:0]       fraction_count_reg;
  logic [7:0]       fraction_count_next;
  logic [7:0]       s_unit_count_reg;
  logic [7:0]       s_unit_count_next;
  logic [7:0]       m_unit_count_reg;
  logic [7:0]       m_unit_count_next;
  logic [7:0]       h_unit_count_reg;
  logic [7:0]       h_unit_count_next;
  logic [7:0]       interval_compare_reg;
  logic [7:0]       interval_compare_next;
  logic [7:0]       interval_count_reg;
  logic [7:0]       interval_count_next;
  logic [7:0]       rdata_reg;
  logic [7:0]       rdata_next;
  logic             irq_reg;
  logic             irq_next;
  logic [8:0]       frac_step;
  logic [8:0]       sec_step;
  logic [8:0]       min_step;
  logic [8:0]       hour_step;
  logic [7:0]       hour_top;
  logic             frac_tick;
  logic             interval_tick;
  logic             timeout;
  logic             control_write;

  // 1/128 s divider, held at zero while the time clock is off
  always_comb begin
    div_next  = div_reg;
    frac_tick = 1'b0;
    if (!control_reg.time_clock_enable) begin
      div_next = '0;
    end else if (div_reg >= DIV_LAST) begin
      div_next  = '0;
      frac_tick = 1'b1;
    end else begin
      div_next = div_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // carries ripple through the whole chain in the same cycle
  always_comb begin
    frac_step = step_wrap(fraction_count_reg, `TIC_FRACTION_TOP, frac_tick);
    sec_step  = step_wrap(s_unit_count_reg, `TIC_SECONDS_TOP, frac_step[8]);
    min_step  = step_wrap(m_unit_count_reg, `TIC_MINUTES_TOP, sec_step[8]);
    if (control_reg.day_wrap_24) begin
      hour_top = `TIC_HOURS24_TOP;
    end else begin
      hour_top = `TIC_HOURS256_TOP;
    end
    hour_step = step_wrap(h_unit_count_reg, hour_top, min_step[8]);
  end

  // a software load wins over a step in the same cycle; that step is lost
  always_comb begin
    fraction_count_next = frac_step[7:0];
    if (sfr_write(sfr_req, `TIC_ADDR_FRACTION)) begin
      fraction_count_next = sfr_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fraction_count_reg <= `TIC_RESET_COUNT;
    end else begin
      fraction_count_reg <= fraction_count_next;
    end
  end

  always_comb begin
    s_unit_count_next = sec_step[7:0];
    if (sfr_write(sfr_req, `TIC_ADDR_SECONDS)) begin
      s_unit_count_next = sfr_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_unit_count_reg <= `TIC_RESET_COUNT;
    end else begin
      s_unit_count_reg <= s_unit_count_next;
    end
  end

  always_comb begin
    m_unit_count_next = min_step[7:0];
    if (sfr_write(sfr_req, `TIC_ADDR_MINUTES)) begin
      m_unit_count_next = sfr_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      m_unit_count_reg <= `TIC_RESET_COUNT;
    end else begin
      m_unit_count_reg <= m_unit_count_next;
    end
  end

  always_comb begin
    h_unit_count_next = hour_step[7:0];
    if (sfr_write(sfr_req, `TIC_ADDR_HOURS)) begin
      h_unit_count_next = sfr_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      h_unit_count_reg <= `TIC_RESET_COUNT;
    end else begin
      h_unit_count_reg <= h_unit_count_next;
    end
  end

  always_comb begin
    interval_compare_next = interval_compare_reg;
    if (sfr_write(sfr_req, `TIC_ADDR_COMPARE)) begin
      interval_compare_next = sfr_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interval_compare_reg <= `TIC_RESET_COMPARE;
    end else begin
      interval_compare_reg <= interval_compare_next;
    end
  end

  // interval rate taken from the carries of the time chain
  always_comb begin
    unique case (timebase_type'(control_reg.timebase_select))
      TB_FRACTION: interval_tick = frac_tick;
      TB_SECONDS:  interval_tick = frac_step[8];
      TB_MINUTES:  interval_tick = sec_step[8];
      TB_HOURS:    interval_tick = min_step[8];
    endcase
  end

  // compared before the increment, so a timeout falls on tick compare+1
  always_comb begin
    interval_count_next = interval_count_reg;
    timeout             = 1'b0;
    if (!control_reg.interval_enable) begin
      interval_count_next = 8'h00;
    end else if (interval_tick) begin
      if (interval_count_reg == interval_compare_reg) begin
        timeout             = 1'b1;
        interval_count_next = 8'h00;
      end else begin
        interval_count_next = interval_count_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interval_count_reg <= 8'h00;
    end else begin
      interval_count_reg <= interval_count_next;
    end
  end

  // the hardware flag set wins over a software clear in the same cycle
  always_comb begin
    control_write = sfr_write(sfr_req, `TIC_ADDR_CONTROL);
    control_next  = control_reg;
    if (control_write) begin
      control_next = tic_control_type'(sfr_req.wdata[6:0]);
    end
    if (timeout && control_reg.single_interval && !control_write) begin
      control_next.interval_enable = 1'b0;
    end
    if (timeout) begin
      control_next.interval_match_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_reg <= tic_control_type'(`TIC_RESET_CONTROL);
    end else begin
      control_reg <= control_next;
    end
  end

  always_comb begin
    irq_next = control_next.interval_match_flag && irq_enable;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // read data holds until the next read strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        `TIC_ADDR_CONTROL:  rdata_next = {1'b0, control_reg} & `TIC_CONTROL_MASK;
        `TIC_ADDR_FRACTION: rdata_next = fraction_count_reg;
        `TIC_ADDR_SECONDS:  rdata_next = s_unit_count_reg;
        `TIC_ADDR_MINUTES:  rdata_next = m_unit_count_reg;
        `TIC_ADDR_HOURS:    rdata_next = h_unit_count_reg;
        `TIC_ADDR_COMPARE:  rdata_next = interval_compare_reg;
        default:            rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata   = rdata_reg;
  assign irq_request = irq_reg;

endmodule

`default_nettype wire

//--- tic_props.sv
`timescale 1ns/100ps
`default_nettype none
module tic_props
  import tic_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire sfr_req_type sfr_req,
  input wire logic        irq_enable,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        irq_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence rd_at(logic [7:0] a);
    sfr_req.rd && sfr_req.addr == a;
  endsequence
  // write of the compare register directly followed by its read
  sequence cmp_wr_rd;
    sfr_req.wr && sfr_req.addr == 8'hA6 ##1 sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'hA6;
  endsequence
  a_irq_masked: assert property (!$past(irq_enable) |-> !irq_request) else $error("irq while masked");
  a_unmapped_read: assert property (sfr_req.rd && (sfr_req.addr < 8'hA1 || sfr_req.addr > 8'hA6)
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata)) else $error("read data moved");
  a_compare_readback: assert property (cmp_wr_rd |=> sfr_rdata == $past(sfr_req.wdata, 2))
    else $error("compare readback wrong");
  a_control_top_bit: assert property (rd_at(8'hA1) |=> !sfr_rdata[7]) else $error("control bit7 set");
  a_fraction_range: assert property (rd_at(8'hA2) |=> sfr_rdata <= 8'h7F) else $error("fraction range");
  a_seconds_range: assert property (rd_at(8'hA3) |=> sfr_rdata <= 8'h3B) else $error("seconds range");
  a_minutes_range: assert property (rd_at(8'hA4) |=> sfr_rdata <= 8'h3B) else $error("minutes range");
endmodule
bind time_interval_counter tic_props chk_u (.clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
  .irq_enable(irq_enable), .sfr_rdata(sfr_rdata), .irq_request(irq_request));
`default_nettype wire

//--- time_interval_counter_test.sv
`timescale 1ns/100ps
`default_nettype none
module time_interval_counter_test
  import tic_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  sfr_req_type sfr_req = '0;
  logic        irq_enable = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        irq_request;
  logic [7:0]  rv;
  int          fails = 0;
  int          n_compared = 0;
  time_interval_counter #(.STEP_CYCLES(4)) dut_u (.clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
    .irq_enable(irq_enable), .sfr_rdata(sfr_rdata), .irq_request(irq_request));
  always #10 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    sfr_req = '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk) #1;
    sfr_req = '0;
    rv = sfr_rdata;
  endtask
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq_request !== 1'b1; i++) @(posedge clk) #1;
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_reset;
    for (int a = 8'hA1; a <= 8'hA7; a++) begin
      acc(1'b0, 8'(a), 8'h00);
      check(rv, 8'h00);
    end
  endtask
  // preset just below every wrap point, let exactly one fraction step ripple through
  task automatic t_wrap(input logic [7:0] ctrl, input logic [7:0] h, input logic [7:0] h_exp);
    acc(1'b1, 8'hA1, 8'h00);
    acc(1'b1, 8'hA2, 8'h7F);
    acc(1'b1, 8'hA3, 8'h3B);
    acc(1'b1, 8'hA4, 8'h3B);
    acc(1'b1, 8'hA5, h);
    acc(1'b1, 8'hA1, ctrl);
    repeat (4) @(posedge clk);
    acc(1'b1, 8'hA1, 8'h00);
    for (int a = 8'hA2; a <= 8'hA4; a++) begin
      acc(1'b0, 8'(a), 8'h00);
      check(rv, 8'h00);
    end
    acc(1'b0, 8'hA5, 8'h00);
    check(rv, h_exp);
  endtask
  task automatic t_second;
    acc(1'b1, 8'hA2, 8'h00);
    acc(1'b1, 8'hA3, 8'h00);
    acc(1'b1, 8'hA1, 8'h01);
    repeat (512) @(posedge clk);
    acc(1'b1, 8'hA1, 8'h00);
    acc(1'b0, 8'hA3, 8'h00);
    check(rv, 8'h01);
    acc(1'b0, 8'hA2, 8'h00);
    check(rv, 8'h00);
  endtask
  task automatic t_interval;
    irq_enable = 1'b1;
    @(posedge clk) #1;
    sfr_req = '{addr: 8'hA6, wdata: 8'h02, wr: 1'b1, rd: 1'b0};
    @(posedge clk) #1;
    sfr_req = '{addr: 8'hA6, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) #1;
    sfr_req = '0;
    check(sfr_rdata, 8'h02);
    acc(1'b1, 8'hA1, 8'h03);
    repeat (8) @(posedge clk) #1;
    check({7'h00, irq_request}, 8'h00);
    wait_irq(8);
    check({7'h00, irq_request}, 8'h01);
    acc(1'b0, 8'hA1, 8'h00);
    check(rv, 8'h07);
    acc(1'b1, 8'hA1, 8'h01);
    acc(1'b0, 8'hA1, 8'h00);
    check(rv, 8'h01);
    check({7'h00, irq_request}, 8'h00);
  endtask
  task automatic t_single;
    irq_enable = 1'b0;
    acc(1'b1, 8'hA6, 8'h00);
    acc(1'b1, 8'hA1, 8'h0B);
    repeat (20) @(posedge clk) #1;
    check({7'h00, irq_request}, 8'h00);
    acc(1'b0, 8'hA1, 8'h00);
    check(rv, 8'h0D);
    irq_enable = 1'b1;
    repeat (2) @(posedge clk) #1;
    check({7'h00, irq_request}, 8'h01);
  endtask
  task automatic t_timebase;
    acc(1'b1, 8'hA1, 8'h00);
    acc(1'b1, 8'hA2, 8'h00);
    acc(1'b1, 8'hA1, 8'h13);
    repeat (300) @(posedge clk);
    acc(1'b0, 8'hA1, 8'h00);
    check(rv, 8'h13);
    repeat (300) @(posedge clk);
    acc(1'b0, 8'hA1, 8'h00);
    check(rv, 8'h17);
  endtask
  initial begin
    #100000;
    fails++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_reset;
    t_wrap(8'h41, 8'h17, 8'h00);
    t_wrap(8'h01, 8'h17, 8'h18);
    t_wrap(8'h01, 8'hFF, 8'h00);
    t_second;
    t_interval;
    t_single;
    t_timebase;
    wrap_up;
  end
endmodule
`default_nettype wire
